//--- common/prs_pkg.sv
package prs_pkg;

	// ****************************************
	// register bus
	// ****************************************
	localparam int         ADDR_WIDTH       = 8;
	localparam int         DATA_WIDTH       = 8;
	localparam logic [7:0] LOGIC_ROUTE_ADDR = 8'h01;
	localparam logic [7:0] SERIAL_LOW_ADDR  = 8'h02;
	localparam logic [7:0] SERIAL_HIGH_ADDR = 8'h03;
	localparam logic [7:0] SYNC_ROUTE_ADDR  = 8'h04;
	localparam logic [7:0] TWO_WIRE_ADDR    = 8'h05;
	localparam logic [7:0] LOGIC_ROUTE_MASK = 8'h01;
	localparam logic [7:0] SERIAL_LOW_MASK  = 8'hff;
	localparam logic [7:0] SERIAL_HIGH_MASK = 8'h0f;
	localparam logic [7:0] SYNC_ROUTE_MASK  = 8'h0f;
	localparam logic [7:0] TWO_WIRE_MASK    = 8'h0f;
	localparam logic [7:0] ROUTE_RESET      = 8'h00;
	localparam logic [7:0] READ_IDLE        = 8'h00;

	// register file indices
	localparam int REG_COUNT       = 5;
	localparam int LOGIC_IDX       = 0;
	localparam int SERIAL_LOW_IDX  = 1;
	localparam int SERIAL_HIGH_IDX = 2;
	localparam int SYNC_IDX        = 3;
	localparam int TWO_WIRE_IDX    = 4;

	// ****************************************
	// pins and signal groups
	// ****************************************
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam int PORT_E = 3;
	localparam int PORT_F = 4;
	localparam int PORT_G = 5;
	localparam int PORT_COUNT = 6;
	localparam int PORT_WIDTH = 8;

	localparam int SERIAL_COUNT = 6;
	localparam int SYNC_COUNT   = 2;
	localparam int GRP_SYNC0    = 6;
	localparam int GRP_TWI_HOST = 8;
	localparam int GRP_TWI_DUAL = 9;
	localparam int GROUP_COUNT  = 10;
	localparam int LANE_COUNT   = 4;

	// lanes: serial tx/rx/clock/dir, sync mosi/miso/sck/ss, two-wire sda/scl
	localparam int LANE_0 = 0;
	localparam int LANE_1 = 1;
	localparam int LANE_2 = 2;
	localparam int LANE_3 = 3;

	localparam int GROUP_REG [GROUP_COUNT] = '{1, 1, 1, 1, 2, 2, 3, 3, 4, 4};
	localparam int GROUP_SHIFT [GROUP_COUNT] = '{0, 2, 4, 6, 0, 2, 0, 2, 2, 2};

	localparam int LUT_IN_BASE     = 0;
	localparam int LUT_OUT_DEFAULT = 3;
	localparam int LUT_OUT_ALT     = 6;

	// ****************************************
	// placements: codes is a bitmap of enabling field values
	// ****************************************
	localparam int PLACE_COUNT = 22;
	localparam int PLACE_GROUP [PLACE_COUNT] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5,
		6, 6, 6, 7, 7, 7, 8, 8, 9, 9};
	localparam int PLACE_PORT [PLACE_COUNT] = '{0, 0, 2, 2, 4, 4, 1, 1, 3, 3, 5, 5,
		0, 3, 5, 2, 2, 1, 4, 1, 1, 1};
	localparam int PLACE_BASE [PLACE_COUNT] = '{0, 4, 0, 4, 0, 4, 0, 4, 0, 4, 0, 4,
		4, 0, 4, 0, 4, 4, 2, 2, 2, 6};
	localparam logic [3:0] PLACE_MASK [PLACE_COUNT] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h3,
		4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf,
		4'h3, 4'h3, 4'h3, 4'h3};
	localparam logic [3:0] PLACE_CODES [PLACE_COUNT] = '{4'h1, 4'h2, 4'h1, 4'h2, 4'h1, 4'h2,
		4'h1, 4'h2, 4'h1, 4'h2, 4'h1, 4'h2, 4'h1, 4'h2, 4'h4, 4'h1, 4'h2, 4'h4,
		4'h3, 4'h4, 4'h1, 4'h6};

	// ****************************************
	// types
	// ****************************************
	typedef logic [PORT_COUNT-1:0][PORT_WIDTH-1:0]  port_bits_type;
	typedef logic [GROUP_COUNT-1:0][LANE_COUNT-1:0] group_bits_type;
	typedef logic [REG_COUNT-1:0][DATA_WIDTH-1:0]   route_file_type;

	typedef struct packed {
		route_file_type        route;
		logic [DATA_WIDTH-1:0] read_data;
	} state_type;

endpackage : prs_pkg

//--- common/prs_place_if.sv
`timescale 1ns/100ps
interface prs_place_if;
	logic       enable;
	logic [3:0] grp_out;
	logic [3:0] grp_oe;
	logic [3:0] grp_in;
	logic [7:0] pad_in;
	logic [7:0] pad_out;
	logic [7:0] pad_oe;

	modport placer (
		input  enable,
		input  grp_out,
		input  grp_oe,
		input  pad_in,
		output grp_in,
		output pad_out,
		output pad_oe
	);

	modport owner (
		output enable,
		output grp_out,
		output grp_oe,
		output pad_in,
		input  grp_in,
		input  pad_out,
		input  pad_oe
	);
endinterface : prs_place_if

//--- core/prs_place.sv
`timescale 1ns/100ps
// ****************************************
// one signal group at one pin position
// ****************************************
module prs_place #(
	parameter int         BASE = 0,
	parameter logic [3:0] MASK = 4'hf
) (
	prs_place_if.placer lane
);
	always_comb begin
		lane.pad_out = 8'h00;
		lane.pad_oe  = 8'h00;
		lane.grp_in  = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (lane.enable && MASK[i]) begin
				lane.pad_out[BASE + i] = lane.grp_out[i] & lane.grp_oe[i];
				lane.pad_oe[BASE + i]  = lane.grp_oe[i];
				lane.grp_in[i]         = lane.pad_in[BASE + i];
			end
		end
	end
endmodule : prs_place

//--- core/prs_route_select.sv
`timescale 1ns/100ps
//Contract
// - logic table 0 output on PA3 (0) or PA6 (1); inputs stay PA0-PA2.
// - serial 3 bits 7:6: 0 PB0-3, 1 PB4-7, 2 reserved, 3 disconnected.
// - serial 2 bits 5:4: 0 PF0-3, 1 tx PF4 rx PF5 only, 3 disconnected.
// - serial 1 bits 3:2: 0 PC0-3, 1 PC4-7, 2 reserved, 3 no pin.
// - serial 0 bits 1:0: 0 PA0-3, 1 PA4-7, 2 reserved, 3 no pin.
// - serial 5 high register bits 3:2: 0 PG0-3, 1 PG4-7, 3 unconnected.
// - serial 4 high register bits 1:0: 0 PE0-3, 1 PE4-7, 3 unconnected.
// - sync port 1 bits 3:2: 0 PC0-3, 1 PC4-7, 2 PB4-7, 3 none.
// - sync port 0 bits 1:0: 0 PA4-7, 1 PE0-3, 2 PG4-7, 3 none.
// - two-wire 1 bits 3:2: host PF2/3 or PB2/3, dual PB2/3 or PB6/7.
module prs_route_select (
	input  logic                                 clk,
	input  logic                                 reset,
	input  logic [prs_pkg::ADDR_WIDTH-1:0]       reg_addr,
	input  logic [prs_pkg::DATA_WIDTH-1:0]       reg_wdata,
	input  logic                                 reg_write,
	input  logic                                 reg_read,
	output logic [prs_pkg::DATA_WIDTH-1:0]       reg_rdata,
	input  prs_pkg::port_bits_type               pad_in,
	output prs_pkg::port_bits_type               pad_out,
	output prs_pkg::port_bits_type               pad_oe,
	input  logic [prs_pkg::SERIAL_COUNT-1:0]     ser_tx,
	output logic [prs_pkg::SERIAL_COUNT-1:0]     ser_rx,
	input  logic [prs_pkg::SERIAL_COUNT-1:0]     serial_clock_line_out,
	input  logic [prs_pkg::SERIAL_COUNT-1:0]     serial_clock_line_oe,
	output logic [prs_pkg::SERIAL_COUNT-1:0]     serial_clock_line_in,
	input  logic [prs_pkg::SERIAL_COUNT-1:0]     direction_control_line,
	input  logic [prs_pkg::SYNC_COUNT-1:0]       spi_mosi_out,
	input  logic [prs_pkg::SYNC_COUNT-1:0]       spi_mosi_oe,
	output logic [prs_pkg::SYNC_COUNT-1:0]       spi_mosi_in,
	input  logic [prs_pkg::SYNC_COUNT-1:0]       spi_miso_out,
	input  logic [prs_pkg::SYNC_COUNT-1:0]       spi_miso_oe,
	output logic [prs_pkg::SYNC_COUNT-1:0]       spi_miso_in,
	input  logic [prs_pkg::SYNC_COUNT-1:0]       spi_sck_out,
	input  logic [prs_pkg::SYNC_COUNT-1:0]       spi_sck_oe,
	output logic [prs_pkg::SYNC_COUNT-1:0]       spi_sck_in,
	input  logic [prs_pkg::SYNC_COUNT-1:0]       spi_ss_out,
	input  logic [prs_pkg::SYNC_COUNT-1:0]       spi_ss_oe,
	output logic [prs_pkg::SYNC_COUNT-1:0]       spi_ss_in,
	input  logic                                 twi_sda_out,
	input  logic                                 twi_sda_oe,
	output logic                                 twi_sda_in,
	input  logic                                 twi_scl_out,
	input  logic                                 twi_scl_oe,
	output logic                                 twi_scl_in,
	input  logic                                 twi_dual_sda_out,
	input  logic                                 twi_dual_sda_oe,
	output logic                                 twi_dual_sda_in,
	input  logic                                 twi_dual_scl_out,
	input  logic                                 twi_dual_scl_oe,
	output logic                                 twi_dual_scl_in,
	input  logic                                 lut_out,
	output logic [2:0]                           lut_in
);
	import prs_pkg::*;

	state_type                              state;
	state_type                              next_state;
	logic [DATA_WIDTH-1:0]                  readback;
	group_bits_type                         grp_out;
	group_bits_type                         grp_oe;
	group_bits_type                         grp_in;
	logic [GROUP_COUNT-1:0][1:0]            field;
	logic [PLACE_COUNT-1:0][PORT_WIDTH-1:0] place_out;
	logic [PLACE_COUNT-1:0][PORT_WIDTH-1:0] place_oe;
	logic [PLACE_COUNT-1:0][LANE_COUNT-1:0] place_gin;
	logic                                   lut_alt;

	// ****************************************
	// register file
	// ****************************************
	always_comb begin
		case (reg_addr)
			LOGIC_ROUTE_ADDR: readback = state.route[LOGIC_IDX] & LOGIC_ROUTE_MASK;
			SERIAL_LOW_ADDR:  readback = state.route[SERIAL_LOW_IDX] & SERIAL_LOW_MASK;
			SERIAL_HIGH_ADDR: readback = state.route[SERIAL_HIGH_IDX] & SERIAL_HIGH_MASK;
			SYNC_ROUTE_ADDR:  readback = state.route[SYNC_IDX] & SYNC_ROUTE_MASK;
			TWO_WIRE_ADDR:    readback = state.route[TWO_WIRE_IDX] & TWO_WIRE_MASK;
			default:          readback = READ_IDLE;
		endcase
	end

	always_comb begin
		next_state = state;
		next_state.read_data = reg_read ? readback : READ_IDLE;
		if (reg_write) begin
			case (reg_addr)
				LOGIC_ROUTE_ADDR: next_state.route[LOGIC_IDX] = reg_wdata & LOGIC_ROUTE_MASK;
				SERIAL_LOW_ADDR:  next_state.route[SERIAL_LOW_IDX] = reg_wdata & SERIAL_LOW_MASK;
				SERIAL_HIGH_ADDR: next_state.route[SERIAL_HIGH_IDX] = reg_wdata & SERIAL_HIGH_MASK;
				SYNC_ROUTE_ADDR:  next_state.route[SYNC_IDX] = reg_wdata & SYNC_ROUTE_MASK;
				TWO_WIRE_ADDR:    next_state.route[TWO_WIRE_IDX] = reg_wdata & TWO_WIRE_MASK;
				default:          next_state.route = state.route;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state.route     <= {REG_COUNT{ROUTE_RESET}};
			state.read_data <= READ_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata = state.read_data;

	// ****************************************
	// peripheral lanes into group vectors
	// ****************************************
	always_comb begin
		grp_out = '0;
		grp_oe  = '0;
		for (int s = 0; s < SERIAL_COUNT; s++) begin
			grp_out[s][LANE_0] = ser_tx[s];
			grp_oe[s][LANE_0]  = 1'h1;
			grp_out[s][LANE_2] = serial_clock_line_out[s];
			grp_oe[s][LANE_2]  = serial_clock_line_oe[s];
			grp_out[s][LANE_3] = direction_control_line[s];
			grp_oe[s][LANE_3]  = 1'h1;
		end
		for (int k = 0; k < SYNC_COUNT; k++) begin
			grp_out[GRP_SYNC0 + k] = {spi_ss_out[k], spi_sck_out[k], spi_miso_out[k], spi_mosi_out[k]};
			grp_oe[GRP_SYNC0 + k]  = {spi_ss_oe[k], spi_sck_oe[k], spi_miso_oe[k], spi_mosi_oe[k]};
		end
		grp_out[GRP_TWI_HOST] = {2'h0, twi_scl_out, twi_sda_out};
		grp_oe[GRP_TWI_HOST]  = {2'h0, twi_scl_oe, twi_sda_oe};
		grp_out[GRP_TWI_DUAL] = {2'h0, twi_dual_scl_out, twi_dual_sda_out};
		grp_oe[GRP_TWI_DUAL]  = {2'h0, twi_dual_scl_oe, twi_dual_sda_oe};
	end

	always_comb begin
		for (int s = 0; s < SERIAL_COUNT; s++) begin
			ser_rx[s]               = grp_in[s][LANE_1];
			serial_clock_line_in[s] = grp_in[s][LANE_2];
		end
		for (int k = 0; k < SYNC_COUNT; k++) begin
			spi_mosi_in[k] = grp_in[GRP_SYNC0 + k][LANE_0];
			spi_miso_in[k] = grp_in[GRP_SYNC0 + k][LANE_1];
			spi_sck_in[k]  = grp_in[GRP_SYNC0 + k][LANE_2];
			spi_ss_in[k]   = grp_in[GRP_SYNC0 + k][LANE_3];
		end
		twi_sda_in      = grp_in[GRP_TWI_HOST][LANE_0];
		twi_scl_in      = grp_in[GRP_TWI_HOST][LANE_1];
		twi_dual_sda_in = grp_in[GRP_TWI_DUAL][LANE_0];
		twi_dual_scl_in = grp_in[GRP_TWI_DUAL][LANE_1];
	end

	// ****************************************
	// route fields and placements
	// ****************************************
	for (genvar g = 0; g < GROUP_COUNT; g++) begin : g_field
		assign field[g] = state.route[GROUP_REG[g]][GROUP_SHIFT[g] +: 2];
	end

	for (genvar p = 0; p < PLACE_COUNT; p++) begin : g_place
		prs_place_if lane ();

		// unlisted codes, reserved ones included, leave the group off every pin
		assign lane.enable  = PLACE_CODES[p][field[PLACE_GROUP[p]]];
		assign lane.grp_out = grp_out[PLACE_GROUP[p]];
		assign lane.grp_oe  = grp_oe[PLACE_GROUP[p]];
		assign lane.pad_in  = pad_in[PLACE_PORT[p]];

		prs_place #(
			.BASE (PLACE_BASE[p]),
			.MASK (PLACE_MASK[p])
		) u_place (
			.lane (lane.placer)
		);

		assign place_out[p] = lane.pad_out;
		assign place_oe[p]  = lane.pad_oe;
		assign place_gin[p] = lane.grp_in;
	end

	// ****************************************
	// pin merge
	// ****************************************
	assign lut_alt = state.route[LOGIC_IDX][0];
	assign lut_in  = pad_in[PORT_A][LUT_IN_BASE +: 3];

	always_comb begin
		pad_out = '0;
		pad_oe  = '0;
		grp_in  = '0;
		for (int p = 0; p < PLACE_COUNT; p++) begin
			pad_out[PLACE_PORT[p]]  = pad_out[PLACE_PORT[p]] | place_out[p];
			pad_oe[PLACE_PORT[p]]   = pad_oe[PLACE_PORT[p]] | place_oe[p];
			grp_in[PLACE_GROUP[p]] = grp_in[PLACE_GROUP[p]] | place_gin[p];
		end
		if (lut_alt) begin
			pad_out[PORT_A][LUT_OUT_ALT] = pad_out[PORT_A][LUT_OUT_ALT] | lut_out;
			pad_oe[PORT_A][LUT_OUT_ALT]  = 1'h1;
		end else begin
			pad_out[PORT_A][LUT_OUT_DEFAULT] = pad_out[PORT_A][LUT_OUT_DEFAULT] | lut_out;
			pad_oe[PORT_A][LUT_OUT_DEFAULT]  = 1'h1;
		end
	end
endmodule : prs_route_select

//--- tb/prs_pin_model.sv
`timescale 1ns/100ps
// ****************************************
// port pins: design drive wins, else bench, else noise
// ****************************************
module prs_pin_model (
	input logic                   clk,
	input logic                   reset,
	input prs_pkg::port_bits_type pad_out,
	input prs_pkg::port_bits_type pad_oe,
	input prs_pkg::port_bits_type ext,
	input prs_pkg::port_bits_type ext_en,
	output prs_pkg::port_bits_type pad_in
);
	import prs_pkg::*;
	port_bits_type noise;
	// floating pins change every cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			noise <= {6{8'h5a}};
		end else begin
			noise <= ~noise;
		end
	end
	assign pad_in = (pad_out & pad_oe) | (~pad_oe & ((ext & ext_en) | (noise & ~ext_en)));
endmodule : prs_pin_model

//--- tb/prs_route_select_bench.sv
`timescale 1ns/100ps
module prs_route_select_bench import prs_pkg::*;;
	localparam int SER_PORT [6] = '{PORT_A, PORT_C, PORT_F, PORT_B, PORT_E, PORT_G};
	localparam int SPI_PORT [8] = '{PORT_A, PORT_E, PORT_G, PORT_A, PORT_C, PORT_C, PORT_B, PORT_C};
	localparam int SPI_BASE [8] = '{4, 0, 4, 4, 0, 4, 4, 0};
	logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, lut_out = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	port_bits_type pad_in, pad_out, pad_oe, ext = '0, ext_en = '0;
	logic [5:0] ser_tx = '0, ser_rx, serial_clock_line_out = '0, serial_clock_line_oe = '0, serial_clock_line_in;
	logic [5:0] direction_control_line = '0;
	logic [1:0] spi_mosi_out = '0, spi_mosi_oe = '0, spi_mosi_in, spi_miso_out = '0, spi_miso_oe = '0, spi_miso_in;
	logic [1:0] spi_sck_out = '0, spi_sck_oe = '0, spi_sck_in, spi_ss_out = '0, spi_ss_oe = '0, spi_ss_in;
	logic twi_sda_out = 1'b0, twi_sda_oe = 1'b0, twi_sda_in, twi_scl_out = 1'b0, twi_scl_oe = 1'b0, twi_scl_in;
	logic twi_dual_sda_out = 1'b0, twi_dual_sda_oe = 1'b0, twi_dual_sda_in;
	logic twi_dual_scl_out = 1'b0, twi_dual_scl_oe = 1'b0, twi_dual_scl_in;
	logic [2:0] lut_in;
	int fails = 0, checked = 0;

	always #2.5 clk = ~clk;
	prs_route_select dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pad_in, .pad_out,
		.pad_oe, .ser_tx, .ser_rx, .serial_clock_line_out, .serial_clock_line_oe, .serial_clock_line_in,
		.direction_control_line, .spi_mosi_out, .spi_mosi_oe, .spi_mosi_in, .spi_miso_out, .spi_miso_oe,
		.spi_miso_in, .spi_sck_out, .spi_sck_oe, .spi_sck_in, .spi_ss_out, .spi_ss_oe, .spi_ss_in, .twi_sda_out,
		.twi_sda_oe, .twi_sda_in, .twi_scl_out, .twi_scl_oe, .twi_scl_in, .twi_dual_sda_out, .twi_dual_sda_oe,
		.twi_dual_sda_in, .twi_dual_scl_out, .twi_dual_scl_oe, .twi_dual_scl_in, .lut_out, .lut_in);
	prs_pin_model model (.clk, .reset, .pad_out, .pad_oe, .ext, .ext_en, .pad_in);

	// ****************************************
	// access and compare tasks
	// ****************************************
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
	endtask : do_reset
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		chk("reg_rdata", reg_rdata, exp);
	endtask : rd
	function automatic logic [5:0] hot(input int kind, input int want, input int n, input logic b);
		return (kind == want && b) ? 6'h1 << n : 6'h0;
	endfunction : hot
	// kind: 0 serial, 1 sync port, 2 two-wire host, 3 two-wire dual, 4 logic table
	task automatic probe(input int kind, input int n, input int port, input int base, input int inl,
		input logic [3:0] mask, input logic on);
		logic [3:0] ol;
		logic [3:0] inv;
		port_bits_type e;
		ol = mask & ~(4'h1 << inl);
		e = '0;
		e[port][base+inl] = mask[inl];
		@(posedge clk);
		ext <= e;
		ext_en <= e;
		ser_tx <= hot(kind, 0, n, ol[0]);
		serial_clock_line_out <= hot(kind, 0, n, ol[2]);
		serial_clock_line_oe <= hot(kind, 0, n, ol[2]);
		direction_control_line <= hot(kind, 0, n, ol[3]);
		spi_mosi_out <= 2'(hot(kind, 1, n, ol[0]));
		spi_mosi_oe <= 2'(hot(kind, 1, n, ol[0]));
		spi_miso_out <= 2'(hot(kind, 1, n, ol[1]));
		spi_miso_oe <= 2'(hot(kind, 1, n, ol[1]));
		spi_sck_out <= 2'(hot(kind, 1, n, ol[2]));
		spi_sck_oe <= 2'(hot(kind, 1, n, ol[2]));
		spi_ss_out <= 2'(hot(kind, 1, n, ol[3]));
		spi_ss_oe <= 2'(hot(kind, 1, n, ol[3]));
		twi_sda_oe <= kind == 2 && ol[0];
		twi_scl_oe <= kind == 2 && ol[1];
		twi_dual_sda_oe <= kind == 3 && ol[0];
		twi_dual_scl_oe <= kind == 3 && ol[1];
		lut_out <= kind == 4;
		@(negedge clk);
		for (int k = 0; k < 4; k++) begin
			if (ol[k]) begin
				chk("pad_oe", pad_oe[port][base+k], on);
				if (kind < 2 || kind == 4) chk("pad_out", pad_out[port][base+k], on);
			end
		end
		case (kind)
			0: inv = {1'b0, serial_clock_line_in[n], ser_rx[n], 1'b0};
			1: inv = {spi_ss_in[n], spi_sck_in[n], spi_miso_in[n], spi_mosi_in[n]};
			2: inv = {2'b00, twi_scl_in, twi_sda_in};
			3: inv = {2'b00, twi_dual_scl_in, twi_dual_sda_in};
			default: inv = 4'h0;
		endcase
		if (mask[inl]) chk("group input", inv[inl], on);
		chk("lut_in", lut_in, pad_in[PORT_A][2:0]);
	endtask : probe
	task automatic end_sim();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		#100000;
		fails++;
		end_sim();
	end
	initial begin
		automatic logic [7:0] masks [5] = '{LOGIC_ROUTE_MASK, SERIAL_LOW_MASK, SERIAL_HIGH_MASK, SYNC_ROUTE_MASK,
			TWO_WIRE_MASK};
		int sh;
		do_reset();
		for (int a = 1; a < 6; a++) begin
			wr(8'(a), 8'hd5);
			rd(8'(a), 8'hd5 & masks[a-1]);
		end
		wr(8'h06, 8'hff);
		rd(8'h06, 8'h00);
		rd(8'h00, 8'h00);
		@(posedge clk);
		reg_addr <= SERIAL_LOW_ADDR;
		reg_wdata <= 8'hd4;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		chk("readback", reg_rdata, 8'hd4);
		do_reset();
		for (int a = 1; a < 6; a++) rd(8'(a), ROUTE_RESET);
		for (int n = 0; n < SERIAL_COUNT; n++) begin
			for (int c = 0; c < 4; c++) begin
				if (c != 2) begin
					sh = 2 * (n % 4);
					wr(n < 4 ? SERIAL_LOW_ADDR : SERIAL_HIGH_ADDR, ~(8'h3 << sh) | 8'(c << sh));
					probe(0, n, SER_PORT[n], c == 1 ? 4 : 0, 1,
						(c == 3 || (n == 2 && c == 1)) ? 4'h3 : 4'hf, c != 3);
					// clock lane input; serial 2 alternate has no clock pin
					probe(0, n, SER_PORT[n], c == 1 ? 4 : 0, 2, (c == 0 || (c == 1 && n != 2)) ? 4'hd : 4'h4,
						c == 0 || (c == 1 && n != 2));
				end
			end
		end
		for (int n = 0; n < SYNC_COUNT; n++) begin
			for (int c = 0; c < 4; c++) begin
				wr(SYNC_ROUTE_ADDR, ~(8'h3 << 2 * n) | 8'(c << 2 * n));
				probe(1, n, SPI_PORT[4*n+c], SPI_BASE[4*n+c], c, 4'hf, c != 3);
			end
		end
		for (int c = 0; c < 3; c++) begin
			wr(TWO_WIRE_ADDR, 8'(c << 2));
			probe(2, 0, c == 2 ? PORT_B : PORT_F, 2, c % 2, 4'h3, 1'b1);
			probe(3, 0, PORT_B, c == 0 ? 2 : 6, 1 - c % 2, 4'h3, 1'b1);
		end
		for (int c = 0; c < 2; c++) begin
			wr(LOGIC_ROUTE_ADDR, 8'(c));
			probe(4, 0, PORT_A, c == 1 ? 6 : 3, 1, 4'h1, 1'b1);
			chk("lut other position", 8'(pad_oe[PORT_A][c == 1 ? 3 : 6]), 8'h00);
		end
		end_sim();
	end
endmodule : prs_route_select_bench

bind prs_route_select prs_rs_properties props (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
	.reg_rdata, .pad_in, .pad_out, .pad_oe, .ser_tx, .ser_rx, .lut_in);

//--- tb/prs_route_select_properties.sv
`timescale 1ns/100ps
// ****************************************
// checks on the top ports
// ****************************************
module prs_rs_properties
	import prs_pkg::*;
(
	input logic                           clk,
	input logic                           reset,
	input logic [prs_pkg::ADDR_WIDTH-1:0] reg_addr,
	input logic [prs_pkg::DATA_WIDTH-1:0] reg_wdata,
	input logic                           reg_write,
	input logic                           reg_read,
	input logic [prs_pkg::DATA_WIDTH-1:0] reg_rdata,
	input prs_pkg::port_bits_type         pad_in,
	input prs_pkg::port_bits_type         pad_out,
	input prs_pkg::port_bits_type         pad_oe,
	input logic [5:0]                     ser_tx,
	input logic [5:0]                     ser_rx,
	input logic [2:0]                     lut_in
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// shadow of the low serial route register
	logic [7:0] low_q;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			low_q <= 8'h00;
		end else if (reg_write && reg_addr == SERIAL_LOW_ADDR) begin
			low_q <= reg_wdata;
		end
	end

	property p_read_idle; !$past(reg_read) |-> reg_rdata == READ_IDLE; endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");
	property p_write_read;
		(reg_write && reg_addr == SERIAL_LOW_ADDR) ##1 (reg_read && reg_addr == SERIAL_LOW_ADDR)
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_write_read: assert property (p_write_read) else $error("readback differs from write");
	property p_high_mask; reg_read && reg_addr == SERIAL_HIGH_ADDR |=> reg_rdata[7:4] == 4'h0; endproperty
	a_high_mask: assert property (p_high_mask) else $error("upper bits not zero");
	property p_unmapped; reg_read && reg_addr > TWO_WIRE_ADDR |=> reg_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_lut_inputs; lut_in == pad_in[PORT_A][2:0]; endproperty
	a_lut_inputs: assert property (p_lut_inputs) else $error("table inputs not on port a");
	property p_reset_default;
		$fell(reset) |-> pad_oe[PORT_A][0] && pad_oe[PORT_C][0] && pad_oe[PORT_F][0]
			&& pad_oe[PORT_B][0] && pad_oe[PORT_E][0] && pad_oe[PORT_G][0];
	endproperty
	a_reset_default: assert property (p_reset_default) else $error("default positions lost");
	property p_ser0_home;
		low_q[1:0] == 2'h0 |-> ser_rx[0] == pad_in[PORT_A][1] && pad_out[PORT_A][0] == ser_tx[0];
	endproperty
	a_ser0_home: assert property (p_ser0_home) else $error("serial 0 default wrong");
	property p_ser0_alt; low_q[1:0] == 2'h1 |-> ser_rx[0] == pad_in[PORT_A][5] && pad_oe[PORT_A][4]; endproperty
	a_ser0_alt: assert property (p_ser0_alt) else $error("serial 0 alternate wrong");
	property p_ser0_none; low_q[1:0] == 2'h3 |-> !ser_rx[0] && !pad_oe[PORT_A][0]; endproperty
	a_ser0_none: assert property (p_ser0_none) else $error("serial 0 still connected");
	property p_ser3_alt; low_q[7:6] == 2'h1 |-> pad_oe[PORT_B][4] && ser_rx[3] == pad_in[PORT_B][5]; endproperty
	a_ser3_alt: assert property (p_ser3_alt) else $error("serial 3 alternate wrong");
endmodule : prs_rs_properties
